// File: lstdr_pkg.sv
package lstdr_pkg;
   localparam int unsigned PIXEL_COUNT = 1024;
   localparam int unsigned WIDE_BITS = 10;
   localparam int unsigned NARROW_BITS = 8;
   // sensor clock period equals one sample of the external clock
   localparam int unsigned HOLD_CYCLES = 4;
   localparam int unsigned RST_GAP_CYCLES = 1;
   // phase load at start fall; hold closes on the rise after it reaches zero
   localparam int unsigned INT_END_CYCLES = 7;
   localparam int unsigned INT_START_CYCLES = 1;
   localparam int unsigned MAX_RATE_HZ = 1000000;
   localparam logic [15:0] PIX_LAST = 16'h03FF;
   localparam logic [3:0] BIT_ZERO = 4'h0;

   typedef enum logic [2:0] {
      LSTDR_IDLE = 3'b000,
      LSTDR_HOLD = 3'b001,
      LSTDR_RESET = 3'b010,
      LSTDR_SCAN = 3'b011,
      LSTDR_DONE = 3'b100
   } lstdr_state_t;
endpackage

// File: lstdr_serializer.sv
module lstdr_serializer
   import lstdr_pkg::*;
#(
   parameter int unsigned WORD_W = 10
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstSync_n,
   // parallel sample
   input wire logic loadStb,
   input wire logic [WORD_W-1:0] sampleWord,
   input wire logic narrowMode,
   // serial out
   output logic serData,
   output logic serValid,
   output logic serLast
);
   logic [WORD_W-1:0] shift_reg, shift_next;
   logic [3:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;
   logic [3:0] loadCnt;

   // narrow mode drops two lsbs, keeps msb first
   assign loadCnt = narrowMode ? 4'(NARROW_BITS - 1) : 4'(WORD_W - 1);

   always_comb begin
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      if (loadStb) begin
         shift_next = sampleWord;
         cnt_next = loadCnt;
         busy_next = 1'b1;
      end else if (busy_reg) begin
         shift_next = {shift_reg[WORD_W-2:0], 1'b0};
         if (cnt_reg == BIT_ZERO) begin
            busy_next = 1'b0;
         end else begin
            cnt_next = cnt_reg - 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         shift_reg <= '0;
         cnt_reg <= BIT_ZERO;
         busy_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
      end
   end

   assign serData = busy_reg & shift_reg[WORD_W-1];
   assign serValid = busy_reg;
   assign serLast = busy_reg & (cnt_reg == BIT_ZERO);
endmodule // lstdr_serializer

// File: lstdr_sequencer.sv
// Functional notes
// - start falling edge restarts timing sequence
// - first step holds every pixel charge
// - photodiode reset follows hold, all pixels
// - no integration while reset asserted
// - scan begins at pixel zero after reset
// - one held pixel routed to converter
// - integration starts half clock after rise
// - integration ends 7.5 clocks after fall
// - integration equals high time plus seven
// - next fall completes cycle, restarts
// - integration runs parallel with readout
// - result shifted out msb first
// - word width 8 or 10 bits
module lstdr_sequencer
   import lstdr_pkg::*;
#(
   parameter int unsigned PIXELS = PIXEL_COUNT,
   parameter int unsigned WORD_W = WIDE_BITS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // driver pins, synchronous to core_clk
   input wire logic startPulse,
   input wire logic sensorClk,
   input wire logic wordSel10,
   // analog front end controls
   output logic holdPulse,
   output logic pdReset,
   output logic integrating,
   output logic [15:0] pixelAddr,
   output logic addrValid,
   // converter
   output logic convStart,
   input wire logic [WORD_W-1:0] convResult,
   input wire logic convDone,
   // serial output
   output logic serData,
   output logic serValid,
   output logic serLast,
   output logic endOfScan
);
   logic rstMeta_reg, rstSync_reg;
   logic start_reg, sclk_reg;
   logic startFall, startRise, sclkRise;
   lstdr_state_t state_reg, state_next;
   logic [3:0] phase_reg, phase_next;
   logic [15:0] pix_reg, pix_next;
   logic wait_reg, wait_next;
   logic narrow_reg, narrow_next;
   logic pdRst_reg, pdRst_next;
   logic hold_reg, hold_next;
   logic [3:0] relCnt_reg, relCnt_next;
   logic relPend_reg, relPend_next;
   logic eos_reg, eos_next;
   logic [15:0] addr_reg;
   logic addrVal_reg;
   logic lastPix;
   logic phaseDone;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         start_reg <= 1'b0;
         sclk_reg <= 1'b0;
      end else begin
         start_reg <= startPulse;
         sclk_reg <= sensorClk;
      end
   end

   assign startFall = start_reg & ~startPulse;
   assign startRise = ~start_reg & startPulse;
   assign sclkRise = ~sclk_reg & sensorClk;
   assign lastPix = (pix_reg == 16'(PIXELS - 1));
   assign phaseDone = sclkRise & (phase_reg == BIT_ZERO);

   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      pix_next = pix_reg;
      wait_next = wait_reg;
      narrow_next = narrow_reg;
      hold_next = hold_reg;
      pdRst_next = pdRst_reg;
      relCnt_next = relCnt_reg;
      relPend_next = relPend_reg;
      eos_next = 1'b0;
      if (sclkRise && phase_reg != BIT_ZERO) begin
         phase_next = phase_reg - 4'h1;
      end
      // integration release counted in sensor clocks after the rise
      if (relPend_reg && sclkRise) begin
         if (relCnt_reg == BIT_ZERO) begin
            pdRst_next = 1'b0;
            relPend_next = 1'b0;
         end else begin
            relCnt_next = relCnt_reg - 4'h1;
         end
      end
      if (startRise && state_reg != LSTDR_HOLD) begin
         relPend_next = 1'b1;
         relCnt_next = 4'(INT_START_CYCLES - 1);
      end
      if (startFall) begin
         // frame restart overrides any unfinished scan
         state_next = LSTDR_HOLD;
         phase_next = 4'(INT_END_CYCLES);
         narrow_next = ~wordSel10;
         hold_next = 1'b0;
         relPend_next = 1'b0;
      end else begin
         case (state_reg)
            LSTDR_IDLE: begin
            end
            LSTDR_HOLD: begin
               // pixels keep integrating until hold closes
               if (phase_reg <= 4'(HOLD_CYCLES)) begin
                  hold_next = 1'b1;
               end
               if (phaseDone) begin
                  hold_next = 1'b0;
                  pdRst_next = 1'b1;
                  state_next = LSTDR_RESET;
                  phase_next = 4'(RST_GAP_CYCLES);
               end
            end
            LSTDR_RESET: begin
               if (phaseDone) begin
                  state_next = LSTDR_SCAN;
                  pix_next = '0;
                  wait_next = 1'b0;
               end
            end
            LSTDR_SCAN: begin
               if (!wait_reg) begin
                  wait_next = 1'b1;
               end else if (convDone) begin
                  wait_next = 1'b0;
                  if (lastPix) begin
                     state_next = LSTDR_DONE;
                     eos_next = 1'b1;
                  end else begin
                     pix_next = pix_reg + 16'h0001;
                  end
               end
            end
            LSTDR_DONE: begin
               state_next = LSTDR_IDLE;
            end
            default: state_next = LSTDR_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         state_reg <= LSTDR_IDLE;
         phase_reg <= BIT_ZERO;
         pix_reg <= '0;
         wait_reg <= 1'b0;
         narrow_reg <= 1'b0;
         hold_reg <= 1'b0;
         pdRst_reg <= 1'b1;
         relCnt_reg <= BIT_ZERO;
         relPend_reg <= 1'b0;
         eos_reg <= 1'b0;
         addr_reg <= '0;
         addrVal_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         pix_reg <= pix_next;
         wait_reg <= wait_next;
         narrow_reg <= narrow_next;
         hold_reg <= hold_next;
         pdRst_reg <= pdRst_next;
         relCnt_reg <= relCnt_next;
         relPend_reg <= relPend_next;
         eos_reg <= eos_next;
         addr_reg <= pix_next;
         addrVal_reg <= (state_next == LSTDR_SCAN);
      end
   end

   assign holdPulse = hold_reg;
   assign pdReset = pdRst_reg;
   assign integrating = ~pdRst_reg;
   assign pixelAddr = addr_reg;
   assign addrValid = addrVal_reg;
   assign convStart = (state_reg == LSTDR_SCAN) & ~wait_reg;
   assign endOfScan = eos_reg;

   lstdr_serializer #(
      .WORD_W(WORD_W)
   ) u_ser (
      .core_clk(core_clk),
      .rstSync_n(rstSync_reg),
      .loadStb(convDone & wait_reg & (state_reg == LSTDR_SCAN)),
      .sampleWord(convResult),
      .narrowMode(narrow_reg),
      .serData(serData),
      .serValid(serValid),
      .serLast(serLast)
   );
endmodule // lstdr_sequencer

// File: lstdr_conv_model.sv
module lstdr_conv_model (
   // clock
   input wire logic core_clk,
   // conversion handshake
   input wire logic convStart,
   input wire logic [15:0] pixelAddr,
   output logic [9:0] convResult = 10'h000,
   output logic convDone = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   logic [4:0] a = 5'h00;
   // 13 cycles apart keeps words from overwriting in the serializer
   // result toggles while not valid so no stale value can pass
   always @(negedge core_clk) begin
      convDone <= (cnt == 1);
      convResult <= (cnt == 1) ? {a, ~a} : ~convResult;
      if (convStart) cnt <= 12;
      else if (cnt > 0) cnt <= cnt - 1;
      if (convStart) a <= pixelAddr[4:0];
   end
endmodule // lstdr_conv_model

// File: lstdr_seq_asserts.sv
module lstdr_seq_asserts
   import lstdr_pkg::*;
#(
   parameter int unsigned PIXELS = PIXEL_COUNT
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // sequencing
   input wire logic startPulse,
   input wire logic holdPulse,
   input wire logic pdReset,
   input wire logic integrating,
   input wire logic [15:0] pixelAddr,
   input wire logic addrValid,
   input wire logic convStart,
   // serial
   input wire logic serValid,
   input wire logic serLast
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   int_inv_a: assert property ($fell(holdPulse) |-> pdReset && !integrating)
      else $error("integrating bad");
   hold_first_a: assert property ($fell(startPulse) |-> ##[1:45] holdPulse)
      else $error("no hold after start fall");
   reset_next_a: assert property ($rose(pdReset) |-> $past(holdPulse) && !holdPulse)
      else $error("reset not after hold");
   scan_zero_a: assert property ($rose(addrValid) |-> pixelAddr == 16'h0000)
      else $error("scan start pixel");
   addr_range_a: assert property (addrValid |-> pixelAddr < PIXELS) else $error("addr");
   conv_req_a: assert property (convStart |-> addrValid ##1 !convStart)
      else $error("conversion request");
   int_start_a: assert property ($rose(integrating) |-> startPulse)
      else $error("integration start");
   word_len_a: assert property ($rose(serValid) |-> (serValid && !serLast) [*7] ##1
      ((serValid && serLast) or (serValid && !serLast) [*2] ##1 (serValid && serLast)))
      else $error("word length");
endmodule // lstdr_seq_asserts
bind lstdr_sequencer lstdr_seq_asserts #(.PIXELS(PIXELS)) chk (
   .core_clk(core_clk),
   .nrst(nrst),
   .startPulse(startPulse),
   .holdPulse(holdPulse),
   .pdReset(pdReset),
   .integrating(integrating),
   .pixelAddr(pixelAddr),
   .addrValid(addrValid),
   .convStart(convStart),
   .serValid(serValid),
   .serLast(serLast)
);

// File: tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import lstdr_pkg::*;
   localparam int unsigned PIX = 4;
   logic core_clk = 0, nrst = 0, startPulse = 0, sensorClk = 0, wordSel10 = 1, scOld = 0;
   logic holdPulse, pdReset, integrating, addrValid, convStart, convDone, serData;
   logic serValid, serLast, endOfScan, wideExp = 1, held = 0;
   logic [15:0] pixelAddr;
   logic [9:0] convResult, word = 10'h000, ev;
   int n = 0, pix = 0, i, bits = 0, scCnt = 0, mismatches = 0, tests_run = 0;
   lstdr_sequencer #(.PIXELS(PIX)) dut (.*);
   lstdr_conv_model conv (.*);
   always #50 core_clk = ~core_clk;
   // free running driver clock at the 1 MHz ceiling
   always @(negedge core_clk) begin
      scCnt <= (scCnt == 4) ? 0 : scCnt + 1;
      if (scCnt == 4) sensorClk <= ~sensorClk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic tick();
      @(negedge core_clk);
      if (sensorClk && !scOld) n++;
      scOld = sensorClk;
      held |= holdPulse;
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return pdReset;
         1: return addrValid;
         2: return integrating;
         default: return endOfScan;
      endcase
   endfunction
   task automatic upTo(input int w);
      for (i = 0; i < 900 && pick(w) !== 1'b1; i++) tick();
      chk("waitFor", 16'h0001, 16'(pick(w)));
   endtask
   // driver moves start only where the sensor clock falls
   task automatic toFall();
      for (i = 0; i < 20 && !(scCnt == 4 && sensorClk); i++) tick();
   endtask
   always @(negedge core_clk) if (serValid) begin
      word = {word[8:0], serData};
      bits++;
      if (serLast) begin
         ev = {pix[4:0], ~pix[4:0]};
         chk("word", 16'(wideExp ? ev : ev[9:2]), 16'(word));
         chk("width", 16'(wideExp ? WIDE_BITS : NARROW_BITS), 16'(bits));
         pix++;
         word = 10'h000;
         bits = 0;
      end
   end
   task automatic frame(input logic wide);
      toFall();
      n = 0;
      pix = 0;
      held = 0;
      wideExp = wide;
      wordSel10 = wide;
      startPulse = 0;
      upTo(0);
      chk("hold", 16'h0001, 16'(held));
      // phase runs down to zero and stops, so hold closes one rise after it reaches zero
      chk("intEnd", 16'(INT_END_CYCLES + 1), 16'(n));
      wordSel10 = ~wide;
      upTo(1);
      toFall();
      n = 0;
      startPulse = 1;
      upTo(2);
      chk("intStart", 16'(INT_START_CYCLES), 16'(n));
      chk("overlap", 16'h0001, 16'(addrValid));
      upTo(3);
      repeat (14) tick();
      chk("pixels", 16'(PIX), 16'(pix));
      $display("frame of %0d bit words done", wide ? WIDE_BITS : NARROW_BITS);
   endtask
   task automatic results();
      $display("tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge core_clk);
      nrst = 1;
      repeat (5) tick();
      toFall();
      startPulse = 1;
      repeat (60) tick();
      frame(1);
      frame(0);
      frame(1);
      results();
   end
   initial begin
      repeat (9000) @(posedge core_clk);
      mismatches++;
      results();
   end
endmodule // tb_top
